// ==== verilog/srt_top.sv ====
`timescale 1ns/10ps
`include "srt_defs.svh"
module srt_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire srt_pkg::srt_cpu_req_s cpu_req,
	output srt_pkg::srt_cpu_rsp_s cpu_rsp,
	input wire logic bus_is_32,
	input wire logic [7:0] refresh_time_constant,
	input wire logic refresh_enable_bit,
	input wire logic refresh_mode_bit,
	input wire logic refresh_done,
	output srt_pkg::srt_mode_cmd_s sdram_mode_cmd,
	output logic refresh_req,
	output logic cmi_irq,
	output logic ovi_irq
);
	srt_pkg::srt_state_s s_ff;
	srt_pkg::srt_state_s nxt_s;
	logic tick;
	logic win2;
	logic win3;
	logic csr_hit;
	logic csr_wr;
	logic match;
	logic cbr_mode;
	logic [9:0] limit;

	srt_prescaler u_presc (
		.mclk(mclk),
		.rst_n(rst_n),
		.cks(s_ff.csr.cks),
		.tick(tick)
	);

	// address decode of the cpu request, timer compare match, cbr mode and refresh limit select
	always_comb begin
		win2 = (cpu_req.addr & `SRT_WIN_MASK) == `SRT_AREA2_BASE; // R05
		win3 = (cpu_req.addr & `SRT_WIN_MASK) == `SRT_AREA3_BASE; // R05
		csr_hit = cpu_req.req && (cpu_req.addr == `SRT_CSR_ADDR);
		csr_wr = csr_hit && cpu_req.we && (cpu_req.size == srt_pkg::SRT_WORD) &&
			(cpu_req.wdata[15:8] == `SRT_KEY); // R09 R26
		match = tick && (s_ff.refresh_timer_counter == refresh_time_constant); // R11
		cbr_mode = refresh_enable_bit && !refresh_mode_bit;
		limit = s_ff.csr.refresh_limit_select ? `SRT_LIMIT_512 : `SRT_LIMIT_1024; // R21
	end

	always_comb begin
		nxt_s = s_ff;
		nxt_s.mode.wr = 1'b0;
		nxt_s.refresh_req = 1'b0;
		nxt_s.rsp.ack = cpu_req.req;
		nxt_s.rsp.rdata = 16'h0000;

		// mode write: value rides on the address, data lanes are dropped
		if (cpu_req.req && cpu_req.we && (win2 || win3)) begin // R01
			nxt_s.mode.wr = 1'b1;
			nxt_s.mode.area3 = win3;
			if (bus_is_32) begin
				nxt_s.mode.addr = {2'h0, cpu_req.addr[11:2]}; // R03 R07
			end else begin
				nxt_s.mode.addr = {1'b0, cpu_req.addr[11:1]}; // R04 R07
			end
		end

		// keyed word write; flags only accept a zero, a one keeps them
		if (csr_wr) begin
			nxt_s.csr = cpu_req.wdata[7:0];
			nxt_s.csr.compare_match_flag = s_ff.csr.compare_match_flag && cpu_req.wdata[`SRT_BIT_CMF]; // R12 R13
			nxt_s.csr.ovf = s_ff.csr.ovf && cpu_req.wdata[`SRT_BIT_OVF]; // R19
		end
		if (refresh_done && cbr_mode) begin
			nxt_s.csr.compare_match_flag = 1'b0; // R12
		end

		if (csr_hit && !cpu_req.we) begin
			nxt_s.rsp.rdata = {8'h00, s_ff.csr}; // R10
		end

		// counting comes last so a set beats a clear in the same cycle
		if (tick) begin
			if (match) begin
				nxt_s.refresh_timer_counter = 8'h00; // R22
			end else begin
				nxt_s.refresh_timer_counter = s_ff.refresh_timer_counter + 8'h01; // R22
			end
		end
		if (match) begin
			nxt_s.csr.compare_match_flag = 1'b1; // R11
			nxt_s.refresh_req = cbr_mode; // R24
			if (s_ff.refresh_count_register == limit) begin
				nxt_s.refresh_count_register = 10'h000; // R23
				nxt_s.csr.ovf = 1'b1; // R18
			end else begin
				nxt_s.refresh_count_register = s_ff.refresh_count_register + 10'h001; // R23
			end
		end

		nxt_s.cmi_irq = nxt_s.csr.compare_match_flag && nxt_s.csr.compare_match_irq_enable; // R14 R25
		nxt_s.ovi_irq = nxt_s.csr.ovf && nxt_s.csr.overflow_irq_enable; // R20 R25
	end

	// rst_n is the power-on reset; nothing here clears on a manual reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_ff <= '0; // R08
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign cpu_rsp = s_ff.rsp;
	assign sdram_mode_cmd = s_ff.mode;
	assign refresh_req = s_ff.refresh_req;
	assign cmi_irq = s_ff.cmi_irq;
	assign ovi_irq = s_ff.ovi_irq;

	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	a_csr_reset: assert property (disable iff (1'b0)
		!rst_n |=> (s_ff.csr == `SRT_CSR_RESET) && (s_ff.refresh_count_register == 10'h000)) // R08
		else $error("control/status not cleared by reset");

	a_bad_key: assert property (
		(csr_hit && cpu_req.we && !csr_wr && !match && !refresh_done)
		|=> (s_ff.csr == $past(s_ff.csr))) // R26
		else $error("control/status changed by an unkeyed write");

	a_key_write: assert property (
		(csr_wr && !match) |=> (s_ff.csr.cks == $past(cpu_req.wdata[5:3]))
		&& (s_ff.csr.refresh_limit_select == $past(cpu_req.wdata[0]))) // R09
		else $error("keyed write did not load the fields");

	a_reserved_zero: assert property (
		(csr_hit && !cpu_req.we) |=> cpu_rsp.ack && (cpu_rsp.rdata[15:8] == 8'h00)
		&& (cpu_rsp.rdata[7:0] == $past(s_ff.csr))) // R10
		else $error("read data wrong or reserved bits set");

	a_cmf_set: assert property (
		match |=> s_ff.csr.compare_match_flag && (s_ff.refresh_timer_counter == 8'h00)) // R11
		else $error("compare match did not set flag and clear counter");

	a_cmf_keep: assert property (
		(csr_wr && cpu_req.wdata[7] && s_ff.csr.compare_match_flag && !(refresh_done && cbr_mode))
		|=> s_ff.csr.compare_match_flag) // R13
		else $error("writing one changed the compare flag");

	a_cmf_clear: assert property (
		(csr_wr && !cpu_req.wdata[7] && !match) |=> !s_ff.csr.compare_match_flag) // R12
		else $error("writing zero did not clear the compare flag");

	a_cmf_refresh: assert property (
		(refresh_done && cbr_mode && !match) |=> !s_ff.csr.compare_match_flag) // R12
		else $error("refresh did not clear the compare flag");

	a_ovf_keep: assert property (
		(s_ff.csr.ovf && !(csr_wr && !cpu_req.wdata[2])) |=> s_ff.csr.ovf) // R19
		else $error("overflow flag lost without a zero write");

	a_ovf_set: assert property (
		(match && (s_ff.refresh_count_register == limit)) |=> s_ff.csr.ovf && (s_ff.refresh_count_register == 10'h000)) // R18
		else $error("overflow not flagged at the limit");

	a_refresh_count_register_step: assert property (
		(match && (s_ff.refresh_count_register != limit)) |=> (s_ff.refresh_count_register == $past(s_ff.refresh_count_register) + 10'h001)) // R23
		else $error("refresh count did not step on a match");

	a_limit_512: assert property (
		s_ff.csr.refresh_limit_select |-> (limit == 10'h1FF)) // R21
		else $error("limit select does not give 512");

	a_refresh_timer_counter_step: assert property (
		(tick && !match) |=> (s_ff.refresh_timer_counter == $past(s_ff.refresh_timer_counter) + 8'h01)) // R22
		else $error("timer counter did not step on a tick");

	a_stop_count: assert property (
		(s_ff.csr.cks == 3'h0) [*3] |-> !tick && $stable(s_ff.refresh_timer_counter)) // R16
		else $error("timer counted with clock stopped");

	a_div4_rate: assert property (
		(tick && (s_ff.csr.cks == 3'h1)) ##1 (s_ff.csr.cks == 3'h1) [*4] |-> tick) // R16
		else $error("divide by four tick spacing wrong");

	a_cmi_irq: assert property (
		cmi_irq == (s_ff.csr.compare_match_flag && s_ff.csr.compare_match_irq_enable)) // R14 R25
		else $error("compare interrupt not flag and enable");

	a_ovi_irq: assert property (
		(s_ff.csr.ovf && s_ff.csr.overflow_irq_enable) ##1 (s_ff.csr.ovf && s_ff.csr.overflow_irq_enable) |-> ovi_irq) // R20 R25
		else $error("overflow interrupt dropped while flag and enable stand");

	a_refresh_start: assert property (
		(match && cbr_mode) |=> refresh_req) // R24
		else $error("compare match in cbr mode started no refresh");

	a_no_refresh: assert property (
		!match |=> !refresh_req) // R24
		else $error("refresh request without a compare match");

	a_mode_addr32: assert property (
		(cpu_req.req && cpu_req.we && win2 && bus_is_32)
		|=> sdram_mode_cmd.wr && !sdram_mode_cmd.area3
		&& (sdram_mode_cmd.addr == {2'h0, $past(cpu_req.addr[11:2])})) // R03
		else $error("mode value not shifted by two on a 32-bit bus");

	a_mode_addr16: assert property (
		(cpu_req.req && cpu_req.we && win3 && !bus_is_32)
		|=> sdram_mode_cmd.wr && sdram_mode_cmd.area3
		&& (sdram_mode_cmd.addr == {1'b0, $past(cpu_req.addr[11:1])})) // R04
		else $error("mode value not shifted by one on a 16-bit bus");

	a_mode_only_window: assert property (
		!(cpu_req.req && cpu_req.we && (win2 || win3)) |=> !sdram_mode_cmd.wr) // R01 R05
		else $error("mode write issued outside its window");

	a_mode_hold: assert property (
		!sdram_mode_cmd.wr ##1 !sdram_mode_cmd.wr |-> $stable(sdram_mode_cmd.addr)) // R07
		else $error("mode value changed without a write");

	a_refused_ack: assert property ( // R26
		(csr_hit && cpu_req.we) |=> cpu_rsp.ack)
		else $error("control/status write not acknowledged");

	a_cmf_only_match: assert property ( // R11
		!match |=> !$rose(s_ff.csr.compare_match_flag))
		else $error("compare flag rose without a match");

	a_ovf_only_limit: assert property ( // R18
		!match |=> !$rose(s_ff.csr.ovf))
		else $error("overflow flag rose without a match");

	a_refresh_timer_counter_hold: assert property ( // R22
		!tick |=> $stable(s_ff.refresh_timer_counter))
		else $error("timer counter moved without a tick");

	a_refresh_count_register_hold: assert property ( // R23
		!match |=> $stable(s_ff.refresh_count_register))
		else $error("refresh count moved without a match");

	a_other_rdata: assert property ( // R10
		!(csr_hit && !cpu_req.we) |=> (cpu_rsp.rdata == 16'h0000))
		else $error("read data not zero outside control/status read");

	a_ovf_clear: assert property ( // R19
		(csr_wr && !cpu_req.wdata[2] && !(match && (s_ff.refresh_count_register == limit))) |=> !s_ff.csr.ovf)
		else $error("writing zero did not clear the overflow flag");

	a_limit_1024: assert property ( // R21
		!s_ff.csr.refresh_limit_select |-> (limit == 10'h3FF))
		else $error("limit select does not give 1024");

	c_mode_write: cover property (cpu_req.req && cpu_req.we && win2 ##1 sdram_mode_cmd.wr);
	c_cbr_refresh: cover property (match && cbr_mode ##1 refresh_req);
	c_overflow: cover property ($rose(s_ff.csr.ovf));
	c_flag_clear: cover property (s_ff.csr.compare_match_flag ##1 !s_ff.csr.compare_match_flag);
endmodule

// ==== pkg/srt_defs.svh ====
// Behaviour
// [R01] mode register write carries its value on address lines; bus data is ignored
// [R02] software writes to mode base address plus value X to program X
// [R03] 32-bit bus: sdram receives X shifted right by two bits
// [R04] 16-bit bus: sdram receives X shifted right by one bit
// [R05] area 2 mode window based at FFFFD000, area 3 window at FFFFE000
// [R06] software keeps offset X between 0000 and 0FFC
// [R07] mode register is 8-bit write-only, held through manual reset and standby
// [R08] control/status register clears to zero on power-on reset only
// [R09] control/status writes need word size and upper byte key A5
// [R10] bits 15 to 8 read zero; software writes zero
// [R11] compare-match flag sets when timer counter equals time constant
// [R12] compare-match flag clears on zero write, or on refresh in cbr mode
// [R13] writing one to compare-match flag leaves it unchanged
// [R14] compare-match enable gates a set flag onto its interrupt request
// [R15] software keeps compare-match enable zero while refresh is in use
// [R16] bits 5 to 3 pick divide 4..4096 of bus clock, 000 stops
// [R17] software sets time constant before a nonzero clock select
// [R18] overflow flag sets when refresh count passes the selected limit
// [R19] overflow flag clears only on zero write; one write leaves it
// [R20] overflow enable gates a set overflow flag onto its interrupt request
// [R21] limit select zero means 1024 refreshes, one means 512
// [R22] 8-bit timer counter counts selected clock and clears on match
// [R23] 10-bit refresh count increments per match, clears past limit, sets overflow
// [R24] in cbr refresh mode a compare match starts a refresh cycle
// [R25] each interrupt request is flag and enable, held while both stand
// [R26] wrong-size or wrong-key control/status writes leave it unchanged
`ifndef SRT_DEFS_SVH
`define SRT_DEFS_SVH
`define SRT_AREA2_BASE 32'hFFFFD000
`define SRT_AREA3_BASE 32'hFFFFE000
`define SRT_WIN_MASK 32'hFFFFF000
`define SRT_CSR_ADDR 32'hFFFFFF00
`define SRT_KEY 8'hA5
`define SRT_CSR_RESET 8'h00
`define SRT_BIT_CMF 7
`define SRT_BIT_OVF 2
`define SRT_LIMIT_1024 10'h3FF
`define SRT_LIMIT_512 10'h1FF
`endif

// ==== pkg/srt_pkg.sv ====
package srt_pkg;
	typedef enum logic [1:0] {
		SRT_BYTE = 2'b00,
		SRT_WORD = 2'b01,
		SRT_LONG = 2'b10
	} srt_size_e;

	typedef struct packed {
		logic req;
		logic we;
		srt_size_e size;
		logic [31:0] addr;
		logic [15:0] wdata;
	} srt_cpu_req_s;

	typedef struct packed {
		logic ack;
		logic [15:0] rdata;
	} srt_cpu_rsp_s;

	typedef struct packed {
		logic compare_match_flag;
		logic compare_match_irq_enable;
		logic [2:0] cks;
		logic ovf;
		logic overflow_irq_enable;
		logic refresh_limit_select;
	} srt_csr_s;

	typedef struct packed {
		logic wr;
		logic area3;
		logic [11:0] addr;
	} srt_mode_cmd_s;

	typedef struct packed {
		logic [11:0] cnt;
		logic tick;
	} srt_presc_s;

	typedef struct packed {
		srt_csr_s csr;
		logic [7:0] refresh_timer_counter;
		logic [9:0] refresh_count_register;
		srt_mode_cmd_s mode;
		logic refresh_req;
		logic cmi_irq;
		logic ovi_irq;
		srt_cpu_rsp_s rsp;
	} srt_state_s;
endpackage

// ==== verilog/srt_prescaler.sv ====
`timescale 1ns/10ps
module srt_prescaler (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [2:0] cks,
	output logic tick
);
	srt_pkg::srt_presc_s s_ff;
	srt_pkg::srt_presc_s nxt_s;
	logic [11:0] mask;

	always_comb begin
		unique case (cks)
			3'h0: mask = 12'h000;
			3'h1: mask = 12'h003;
			3'h2: mask = 12'h00F;
			3'h3: mask = 12'h03F;
			3'h4: mask = 12'h0FF;
			3'h5: mask = 12'h3FF;
			3'h6: mask = 12'h7FF;
			3'h7: mask = 12'hFFF;
		endcase
	end

	// free divider; select 000 holds it at zero so no tick comes out
	always_comb begin
		nxt_s = s_ff;
		nxt_s.tick = 1'b0;
		if (cks == 3'h0) begin // R16
			nxt_s.cnt = 12'h000;
		end else begin
			nxt_s.cnt = s_ff.cnt + 12'h001;
			nxt_s.tick = ((s_ff.cnt & mask) == mask); // R16
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign tick = s_ff.tick;
endmodule

// ==== bench/srt_sdram_model.sv ====
`timescale 1ns/10ps
module srt_sdram_model #(
	parameter int DELAY = 3
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire srt_pkg::srt_mode_cmd_s mode_cmd,
	input wire logic refresh_req,
	output logic refresh_done,
	output logic [11:0] mode_val
);
	int wait_ff;
	// a refresh occupies the memory a few cycles, then reports once
	always_ff @(posedge mclk) begin
		refresh_done <= 1'h0;
		if (!rst_n) begin
			wait_ff <= 0;
		end else if (refresh_req) begin
			wait_ff <= DELAY;
		end else if (wait_ff > 0) begin
			wait_ff <= wait_ff - 1;
			refresh_done <= (wait_ff == 1);
		end
	end
	// mode value is taken from the address lines only
	always_ff @(posedge mclk) begin
		if (mode_cmd.wr) begin
			mode_val <= mode_cmd.addr;
		end
	end
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
`include "srt_defs.svh"
module tb_top;
	logic mclk = 1'h0;
	logic rst_n = 1'h0;
	srt_pkg::srt_cpu_req_s cpu_req = '0;
	srt_pkg::srt_cpu_rsp_s cpu_rsp;
	srt_pkg::srt_mode_cmd_s mode_cmd;
	logic bus_is_32 = 1'h1;
	logic [7:0] rtc = 8'h00;
	logic rf_en = 1'h0;
	logic rf_mode = 1'h0;
	logic refresh_done;
	logic refresh_req;
	logic cmi_irq;
	logic ovi_irq;
	logic [11:0] mode_val;
	logic [15:0] rd;
	int bad_count = 0;
	int compares = 0;
	int n;
	int r;
	int dv[7] = '{4, 16, 64, 256, 1024, 2048, 4096};
	always #10 mclk = ~mclk;
	srt_top srt_top_i (.mclk(mclk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .bus_is_32(bus_is_32),
		.refresh_time_constant(rtc), .refresh_enable_bit(rf_en), .refresh_mode_bit(rf_mode),
		.refresh_done(refresh_done), .sdram_mode_cmd(mode_cmd), .refresh_req(refresh_req),
		.cmi_irq(cmi_irq), .ovi_irq(ovi_irq));
	srt_sdram_model srt_sdram_model_i (.mclk(mclk), .rst_n(rst_n), .mode_cmd(mode_cmd),
		.refresh_req(refresh_req), .refresh_done(refresh_done), .mode_val(mode_val));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic we, input srt_pkg::srt_size_e sz, input logic [31:0] a, input logic [15:0] d);
		@(posedge mclk) #1;
		cpu_req = '{1'h1, we, sz, a, d};
		@(posedge mclk) #1;
		cpu_req.req = 1'h0;
		rd = cpu_rsp.rdata;
		chk({15'h0000, cpu_rsp.ack}, 16'h0001);
	endtask
	task automatic wr(input logic [15:0] d);
		acc(1'h1, srt_pkg::SRT_WORD, `SRT_CSR_ADDR, d);
	endtask
	task automatic rdcsr();
		acc(1'h0, srt_pkg::SRT_WORD, `SRT_CSR_ADDR, 16'h0000);
	endtask
	// waits for an interrupt line, counting cycles and refresh starts
	task automatic wt(input logic ov, input int lim);
		n = 0;
		r = 0;
		while ((ov ? ovi_irq : cmi_irq) !== 1'h1 && n < lim) begin
			@(posedge mclk) #1;
			n++;
			if (refresh_req === 1'h1) r++;
		end
	endtask
	task automatic t_reset();
		chk({13'h0000, refresh_req, cmi_irq, ovi_irq}, 16'h0000);
		rdcsr();
		chk(rd, 16'h0000);
	endtask
	task automatic t_mode();
		acc(1'h1, srt_pkg::SRT_LONG, 32'hFFFFD8C0, 16'hDEAD);
		chk({mode_cmd.wr, mode_cmd.area3, 2'h0, mode_cmd.addr}, 16'h8230);
		@(posedge mclk) #1;
		chk({4'h0, mode_val}, 16'h0230);
		bus_is_32 = 1'h0;
		acc(1'h1, srt_pkg::SRT_WORD, 32'hFFFFEFFC, 16'h1234);
		chk({mode_cmd.wr, mode_cmd.area3, 2'h0, mode_cmd.addr}, 16'hC7FE);
		acc(1'h1, srt_pkg::SRT_LONG, 32'hFFFFCFFC, 16'h0000);
		chk({mode_cmd.wr, mode_cmd.area3, 2'h0, mode_cmd.addr}, 16'h47FE);
		bus_is_32 = 1'h1;
	endtask
	task automatic t_key();
		wr(16'h5A43);
		rdcsr();
		chk(rd, 16'h0000);
		acc(1'h1, srt_pkg::SRT_BYTE, `SRT_CSR_ADDR, 16'hA543);
		rdcsr();
		chk(rd, 16'h0000);
		wr(16'hA543);
		rdcsr();
		chk(rd, 16'h0043);
		wr(16'hA500);
	endtask
	task automatic t_ovf(input logic lm, input logic [15:0] cnt);
		rf_en = 1'h1;
		rtc = 8'h00;
		wr({8'hA5, 5'h01, 2'h1, lm});
		wt(1'h1, 5000);
		chk(16'(r), cnt);
		wr({8'hA5, 5'h00, 2'h3, lm});
		rdcsr();
		chk(rd & 16'hFF7F, {13'h0000, 2'h3, lm});
		chk({15'h0000, ovi_irq}, 16'h0001);
		wr(16'hA500);
		rdcsr();
		chk(rd & 16'hFF7F, 16'h0000);
		chk({15'h0000, ovi_irq}, 16'h0000);
		rf_en = 1'h0;
	endtask
	task automatic t_cks();
		for (int k = 1; k < 8; k++) begin
			wr({8'hA5, 2'h1, 3'(k), 3'h0});
			wt(1'h0, 5000);
			chk({15'h0000, n >= dv[k - 1] && n <= dv[k - 1] + 3}, 16'h0001);
			wr(16'hA500);
		end
		wr(16'hA540);
		repeat (100) @(posedge mclk);
		#1;
		chk({15'h0000, cmi_irq}, 16'h0000);
	endtask
	task automatic t_cmf();
		rtc = 8'h02;
		wr(16'hA548);
		wt(1'h0, 100);
		chk({15'h0000, n >= 12 && n <= 15}, 16'h0001);
		chk(16'(r), 16'h0000);
		wr(16'hA5C0);
		rdcsr();
		chk(rd, 16'h00C0);
		chk({15'h0000, cmi_irq}, 16'h0001);
		wr(16'hA580);
		rdcsr();
		chk(rd, 16'h0080);
		chk({15'h0000, cmi_irq}, 16'h0000);
		wr(16'hA540);
		rdcsr();
		chk(rd, 16'h0040);
		wr(16'hA500);
	endtask
	task automatic give_verdict();
		if (bad_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		#1;
		rst_n = 1'h1;
		t_reset();
		t_mode();
		t_key();
		t_ovf(1'h1, 16'h0200);
		t_ovf(1'h0, 16'h0400);
		t_cks();
		t_cmf();
		give_verdict();
	end
	initial begin
		repeat (30000) @(posedge mclk);
		bad_count++;
		give_verdict();
	end
endmodule
